// [hdl/codec_path_power_regs.sv]
// Path select, power-down and warm reset registers behind an AXI4-Lite slave
`timescale 1ns/1ps
`default_nettype none
module codec_path_power_regs #(
   parameter int ADDR_W = 12
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic warm_reset_pin,
   output codec_regs_pkg::path_ctl_t path_ctl,
   output codec_regs_pkg::pd_out_t pd_state,
   output logic warm_reset_pulse
);
   import codec_regs_pkg::*;

   logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
   logic [1:0] bresp_ff, rresp_ff;
   logic [31:0] rdata_ff;
   logic aw_held_ff, w_held_ff;
   logic [ADDR_W-1:0] aw_addr_ff;
   logic [7:0] w_data_ff;
   logic w_lane0_ff;
   logic [7:0] path_ff, pd_ff;
   logic iface_halt_ff;
   logic pin_s1_ff, pin_s2_ff, pin_s3_ff;
   logic warm_pulse_ff;
   path_ctl_t path_ctl_ff;
   pd_out_t pd_state_ff;
   logic aw_take, w_take, do_write, ar_take;
   logic nxt_aw_held, nxt_w_held, nxt_bvalid, nxt_rvalid;
   logic [7:0] wr_idx, rd_idx;
   logic wr_in_range, rd_in_range;
   logic wr_path, wr_pd, wr_warm, warm_cmd, pin_rise, warm_evt;
   logic [1:0] nxt_bresp;

   // -------------------------------------------------------------------
   // Write channel handshake
   // -------------------------------------------------------------------
   // Address and data are caught in either order; commit needs both
   assign aw_take = awvalid & awready_ff;
   assign w_take = wvalid & wready_ff;
   assign do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
   assign nxt_aw_held = (aw_held_ff | aw_take) & ~do_write;
   assign nxt_w_held = (w_held_ff | w_take) & ~do_write;
   assign nxt_bvalid = do_write | (bvalid_ff & ~bready);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_ff <= 1'b0;
         w_held_ff <= 1'b0;
         awready_ff <= 1'b0;
         wready_ff <= 1'b0;
         bvalid_ff <= 1'b0;
      end else begin
         aw_held_ff <= nxt_aw_held;
         w_held_ff <= nxt_w_held;
         // Ready drops while a word is held so a second one cannot slip in
         awready_ff <= ~nxt_aw_held & ~nxt_bvalid;
         wready_ff <= ~nxt_w_held & ~nxt_bvalid;
         bvalid_ff <= nxt_bvalid;
      end
   end

   // Payload capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_addr_ff <= '0;
         w_data_ff <= 8'h00;
         w_lane0_ff <= 1'b0;
      end else begin
         if (aw_take) begin
            aw_addr_ff <= awaddr;
         end
         if (w_take) begin
            w_data_ff <= wdata[7:0];
            w_lane0_ff <= wstrb[0];
         end
      end
   end

   // -------------------------------------------------------------------
   // Write decode
   // -------------------------------------------------------------------
   // Registers are 8 bits wide; only byte lane 0 carries them
   assign wr_idx = aw_addr_ff[9:2];
   assign wr_in_range = (aw_addr_ff[ADDR_W-1:10] == '0);
   assign wr_path = do_write & ~iface_halt_ff & wr_in_range
                    & (wr_idx == IDX_PATH_WR) & w_lane0_ff;
   assign wr_pd = do_write & ~iface_halt_ff & wr_in_range
                  & (wr_idx == IDX_PD_WR) & w_lane0_ff;
   assign wr_warm = do_write & ~iface_halt_ff & wr_in_range
                    & (wr_idx == IDX_WARM) & w_lane0_ff;
   assign warm_cmd = wr_warm & (w_data_ff == WARM_CMD);

   // Halted interface and unmapped words answer with an error
   always_comb begin
      nxt_bresp = RESP_SLVERR;
      if (!iface_halt_ff && wr_in_range
          && (wr_idx == IDX_PATH_WR || wr_idx == IDX_PD_WR
              || wr_idx == IDX_WARM)) begin
         nxt_bresp = RESP_OKAY;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bresp_ff <= RESP_OKAY;
      end else if (do_write) begin
         bresp_ff <= nxt_bresp;
      end
   end

   // -------------------------------------------------------------------
   // Warm reset sources
   // -------------------------------------------------------------------
   // Pin crosses in through two flops; edge taken past the second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_s1_ff <= 1'b0;
         pin_s2_ff <= 1'b0;
         pin_s3_ff <= 1'b0;
      end else begin
         pin_s1_ff <= warm_reset_pin;
         pin_s2_ff <= pin_s1_ff;
         pin_s3_ff <= pin_s2_ff;
      end
   end

   assign pin_rise = pin_s2_ff & ~pin_s3_ff;
   // Pin is the only way back once the interface itself is down
   assign warm_evt = warm_cmd | pin_rise;

   // Warm reset pulse; the trigger word itself is never stored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         warm_pulse_ff <= 1'b0;
      end else begin
         warm_pulse_ff <= warm_evt;
      end
   end

   // -------------------------------------------------------------------
   // Control registers
   // -------------------------------------------------------------------
   // Fixed positions are forced on every write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         path_ff <= RST_PATH;
      end else if (wr_path) begin
         path_ff <= (w_data_ff & ~PATH_FIXED_MASK) | PATH_FIXED_VAL;
      end
   end

   // Warm reset leaves this register alone, so the digital bit stays set
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pd_ff <= RST_PD;
      end else if (wr_pd) begin
         pd_ff <= (w_data_ff & ~PD_FIXED_MASK) | PD_FIXED_VAL;
      end
   end

   // Host interface halts when the digital core is powered down.
   // A warm reset in the same cycle wins so access is never lost for good.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         iface_halt_ff <= 1'b0;
      end else if (warm_evt) begin
         iface_halt_ff <= 1'b0;
      end else if (wr_pd && w_data_ff[PD_DIG_BIT]) begin
         iface_halt_ff <= 1'b1;
      end
   end

   // -------------------------------------------------------------------
   // Read channel
   // -------------------------------------------------------------------
   assign ar_take = arvalid & arready_ff;
   assign nxt_rvalid = ar_take | (rvalid_ff & ~rready);
   assign rd_idx = araddr[9:2];
   assign rd_in_range = (araddr[ADDR_W-1:10] == '0);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b0;
         rvalid_ff <= 1'b0;
      end else begin
         arready_ff <= ~nxt_rvalid;
         rvalid_ff <= nxt_rvalid;
      end
   end

   // Read indices sit 80h above write ones; warm word is not readable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= RESP_OKAY;
      end else if (ar_take) begin
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= RESP_SLVERR;
         if (!iface_halt_ff && rd_in_range) begin
            if (rd_idx == IDX_PATH_RD) begin
               rdata_ff <= {24'h00_0000, path_ff};
               rresp_ff <= RESP_OKAY;
            end else if (rd_idx == IDX_PD_RD) begin
               rdata_ff <= {24'h00_0000, pd_ff};
               rresp_ff <= RESP_OKAY;
            end
         end
      end
   end

   // -------------------------------------------------------------------
   // Control outputs
   // -------------------------------------------------------------------
   // One cycle behind the register; analog switching tolerates this lag
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         path_ctl_ff <= '0;
      end else begin
         path_ctl_ff.mono_src_mic <= path_ff[PATH_MONO_BIT];
         path_ctl_ff.microphone_input_select <=
            path_ff[PATH_MICSEL_BIT];
         path_ctl_ff.mic_boost_select <= path_ff[PATH_BOOST_BIT];
         path_ctl_ff.analog_loopback_enable <=
            path_ff[PATH_ANALOG_LOOPBACK_ENABLE_BIT];
      end
   end

   // Each circuit but the host interface is down when any bit that covers it is set
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pd_state_ff <= '0;
      end else begin
         pd_state_ff.adc <= pd_ff[PD_DIG_BIT] | pd_ff[PD_VREF_BIT]
                            | pd_ff[PD_ADC_BIT];
         pd_state_ff.dac <= pd_ff[PD_DIG_BIT] | pd_ff[PD_VREF_BIT]
                            | pd_ff[PD_DAC_BIT];
         pd_state_ff.mixer_vol <= pd_ff[PD_VREF_BIT]
                                  | pd_ff[PD_MIX_BIT];
         pd_state_ff.master_vol <= pd_ff[PD_VREF_BIT]
                                   | pd_ff[PD_MIX_BIT];
         pd_state_ff.vref <= pd_ff[PD_VREF_BIT];
         pd_state_ff.host_iface <= iface_halt_ff;
         pd_state_ff.int_clock <= pd_ff[PD_DIG_BIT];
      end
   end

   assign awready = awready_ff;
   assign wready = wready_ff;
   assign bvalid = bvalid_ff;
   assign bresp = bresp_ff;
   assign arready = arready_ff;
   assign rvalid = rvalid_ff;
   assign rdata = rdata_ff;
   assign rresp = rresp_ff;
   assign path_ctl = path_ctl_ff;
   assign pd_state = pd_state_ff;
   assign warm_reset_pulse = warm_pulse_ff;

   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   chk_path_fixed: assert property (
      (path_ff & PATH_FIXED_MASK) == PATH_FIXED_VAL)
      else $error("path select fixed bits wrong");

   chk_pd_fixed: assert property (
      (pd_ff & PD_FIXED_MASK) == PD_FIXED_VAL)
      else $error("power-down fixed bits wrong");

   chk_cold_values: assert property (
      !$past(aresetn) |-> pd_ff == RST_PD && path_ff == RST_PATH
                          && !iface_halt_ff)
      else $error("cold reset values wrong");

   chk_path_route: assert property (
      wr_path |=> ##1 path_ctl.mono_src_mic == $past(w_data_ff[3], 2)
         && path_ctl.analog_loopback_enable == $past(w_data_ff[0], 2))
      else $error("path fields not routed");

   chk_mic_fields: assert property (
      wr_path |=> ##1 path_ctl.microphone_input_select
                        == $past(w_data_ff[2], 2)
         && path_ctl.mic_boost_select == $past(w_data_ff[1], 2))
      else $error("mic fields not routed");

   chk_pd_write: assert property (
      wr_pd |=> pd_ff[4:0] == $past(w_data_ff[4:0]))
      else $error("power-down write lost");

   chk_dig_map: assert property (
      pd_ff[4:0] == 5'b10000 |=> pd_state.adc && pd_state.dac
         && pd_state.int_clock && !pd_state.mixer_vol && !pd_state.vref)
      else $error("digital power-down map wrong");

   chk_vref_map: assert property (
      pd_ff[4:0] == 5'b01000 |=> pd_state.adc && pd_state.dac
         && pd_state.mixer_vol && pd_state.master_vol && pd_state.vref
         && !pd_state.int_clock)
      else $error("analog power-down map wrong");

   chk_mix_only: assert property (
      pd_ff[4:0] == 5'b00100 |=> !pd_state.adc && !pd_state.dac
         && pd_state.mixer_vol && pd_state.master_vol && !pd_state.vref)
      else $error("volume power-down map wrong");

   chk_conv_only: assert property (
      pd_ff[4:0] == 5'b00010 |=> pd_state.dac && !pd_state.adc
         && !pd_state.mixer_vol)
      else $error("DAC power-down map wrong");

   chk_warm_keeps: assert property (
      warm_evt && pd_ff[PD_DIG_BIT] && !wr_pd |=> pd_ff[PD_DIG_BIT]
         && !iface_halt_ff ##1 pd_state.int_clock && !pd_state.host_iface)
      else $error("warm reset handling wrong");

   chk_warm_pulse: assert property (
      warm_cmd |=> warm_reset_pulse ##1 !warm_reset_pulse)
      else $error("warm reset pulse wrong");

   cov_warm_cmd: cover property (warm_cmd);
   cov_halt_release: cover property (iface_halt_ff ##[1:50] pin_rise);
   cov_loopback: cover property (path_ctl.analog_loopback_enable);
endmodule
`default_nettype wire

// [hdl/codec_regs_pkg.sv]
// Constants, field layouts and carrier types for the codec control registers
//
// Functional notes
// - Path select written at index 17h, read at 97h, reset 50h, D7/D5=0, D4=1.
// - Mono source field: 0 feeds mixer mono signal, 1 feeds microphone signal.
// - Microphone input select: 0 picks input one, 1 picks input two.
// - Mic boost select: 0 gives +0 dB, 1 gives +20 dB.
// - Loopback enable 1 feeds ADC output straight into DAC; 0 is off.
// - Power-down register at 18h, read at 98h; a 1 powers the group down.
// - Power-down reset value conflicts, 40h versus 43h; one is chosen, flagged.
// - Digital core bit downs ADC, DAC, host interface, internal clock only.
// - Analog core bit downs ADC, DAC, both volume stages and reference.
// - Volume stage bit downs mixer and master volume only, analog core on.
// - DAC bit downs only the DAC; ADC bit downs only the ADC.
// - Cold reset clears digital power-down; warm reset restores register access.
// - After warm reset the digital core bit stays 1, some logic halted.
// - Writing FFh at index 7Fh performs a warm reset; register resets 00h.
package codec_regs_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_PATH_WR = 8'h17;
   localparam logic [7:0] IDX_PATH_RD = 8'h97;
   localparam logic [7:0] IDX_PD_WR = 8'h18;
   localparam logic [7:0] IDX_PD_RD = 8'h98;
   localparam logic [7:0] IDX_WARM = 8'h7f;
   // Values after reset
   localparam logic [7:0] RST_PATH = 8'h50;
   // 43h taken; a conflicting figure of 40h exists, flagged as still open
   localparam logic [7:0] RST_PD = 8'h43;
   // Command that triggers a warm reset
   localparam logic [7:0] WARM_CMD = 8'hff;
   // Fixed bit positions and the values they read
   localparam logic [7:0] PATH_FIXED_MASK = 8'hb0;
   localparam logic [7:0] PATH_FIXED_VAL = 8'h10;
   localparam logic [7:0] PD_FIXED_MASK = 8'ha0;
   localparam logic [7:0] PD_FIXED_VAL = 8'h00;
   // Path select field positions
   localparam int PATH_MONO_BIT = 3;
   localparam int PATH_MICSEL_BIT = 2;
   localparam int PATH_BOOST_BIT = 1;
   localparam int PATH_ANALOG_LOOPBACK_ENABLE_BIT = 0;
   // Power-down field positions
   localparam int PD_DIG_BIT = 4;
   localparam int PD_VREF_BIT = 3;
   localparam int PD_MIX_BIT = 2;
   localparam int PD_DAC_BIT = 1;
   localparam int PD_ADC_BIT = 0;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef struct packed {
      logic mono_src_mic;
      logic microphone_input_select;
      logic mic_boost_select;
      logic analog_loopback_enable;
   } path_ctl_t;

   typedef struct packed {
      logic adc;
      logic dac;
      logic mixer_vol;
      logic master_vol;
      logic vref;
      logic host_iface;
      logic int_clock;
   } pd_out_t;
endpackage

// [bench/host_model.sv]
// Host controller model that drives the register bus as an AXI4-Lite master
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input wire logic aclk,
   output logic [11:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   output logic [11:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   // -------------------------------------------------------------
   // Idle values at time zero
   // -------------------------------------------------------------
   initial begin
      awaddr = 12'h000;
      awvalid = 1'b0;
      wdata = 32'h0;
      wstrb = 4'h0;
      wvalid = 1'b0;
      bready = 1'b0;
      araddr = 12'h000;
      arvalid = 1'b0;
      rready = 1'b0;
   end

   // One write; address and data go out together and drop when taken.
   // Released payloads flip so a slave that samples late sees garbage.
   task automatic wr(input logic [11:0] a, input logic [7:0] d,
                     input logic s, output logic [1:0] r);
      int n;
      logic aw_done;
      logic w_done;
      n = 0;
      aw_done = 1'b0;
      w_done = 1'b0;
      r = 2'bxx;
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= {24'h0, d};
      wstrb <= {3'b000, s};
      wvalid <= 1'b1;
      bready <= 1'b1;
      // No cycle limit here; a hang is ended by the bench watchdog
      while (n == 0) begin
         @(posedge aclk);
         if (awvalid && awready === 1'b1) begin
            awvalid <= 1'b0;
            awaddr <= ~a;
            aw_done = 1'b1;
         end
         if (wvalid && wready === 1'b1) begin
            wvalid <= 1'b0;
            wdata <= ~{24'h0, d};
            w_done = 1'b1;
         end
         if (aw_done && w_done && bvalid === 1'b1) begin
            r = bresp;
            bready <= 1'b0;
            n = 1;
         end
      end
   endtask

   // One read; rready stays up until the data beat is seen
   task automatic rd(input logic [11:0] a, output logic [7:0] d,
                     output logic [1:0] r);
      int n;
      logic ar_done;
      n = 0;
      ar_done = 1'b0;
      r = 2'bxx;
      d = 8'hxx;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (n == 0) begin
         @(posedge aclk);
         if (arvalid && arready === 1'b1) begin
            arvalid <= 1'b0;
            araddr <= ~a;
            ar_done = 1'b1;
         end
         if (ar_done && rvalid === 1'b1) begin
            r = rresp;
            d = rdata[7:0];
            rready <= 1'b0;
            n = 1;
         end
      end
   endtask
endmodule
`default_nettype wire

// [bench/codec_path_power_reset_regs_bench.sv]
// Self-checking bench for the codec path and power-down registers
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
   fail_count++; $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); \
   end end
module codec_path_power_reset_regs_bench;
   import codec_regs_pkg::*;
   // -------------------------------------------------------------
   // Signals, byte addresses and counters
   // -------------------------------------------------------------
   localparam logic [11:0] A_PW = 12'({IDX_PATH_WR, 2'b00});
   localparam logic [11:0] A_PR = 12'({IDX_PATH_RD, 2'b00});
   localparam logic [11:0] A_DW = 12'({IDX_PD_WR, 2'b00});
   localparam logic [11:0] A_DR = 12'({IDX_PD_RD, 2'b00});
   localparam logic [11:0] A_WM = 12'({IDX_WARM, 2'b00});
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic warm_reset_pin = 1'b0;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, warm_reset_pulse;
   logic [7:0] d;
   path_ctl_t path_ctl;
   pd_out_t pd_state;
   int fail_count = 0;
   int compares = 0;
   int pulses = 0;
   logic [6:0] pd_map [4] = '{7'b1000000, 7'b0100000, 7'b0011000,
                              7'b1111100};

   initial begin
      forever #5 aclk = ~aclk;
   end

   // Count warm reset pulses so a missing or doubled one shows
   always @(posedge aclk) begin
      if (warm_reset_pulse === 1'b1) pulses <= pulses + 1;
   end

   host_model hm_u (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

   codec_path_power_regs #(.ADDR_W(12)) dut_u (.aclk(aclk),
      .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .warm_reset_pin(warm_reset_pin), .path_ctl(path_ctl),
      .pd_state(pd_state), .warm_reset_pulse(warm_reset_pulse));

   // -------------------------------------------------------------
   // Verdict and hang guard
   // -------------------------------------------------------------
   task automatic close_out;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // Whole run needs about 150 cycles; the margin is generous
   initial begin
      repeat (20000) @(posedge aclk);
      fail_count++;
      close_out();
   end

   // Outputs follow the register one cycle after the response
   task automatic settle;
      repeat (2) @(posedge aclk);
   endtask

   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      // Reset values and their effect on the outputs
      hm_u.rd(A_PR, d, r);
      `CHECK("path reset", RST_PATH, d)
      `CHECK("rdata upper", 24'h000000, rdata[31:8])
      hm_u.rd(A_DR, d, r);
      `CHECK("pd reset", 8'h43, d)
      `CHECK("pd_state reset", 7'b1100000, pd_state)
      `CHECK("path_ctl reset", 4'h0, path_ctl)
      $display("test reset done");
      // Each path field alone, fixed bits written inverted
      for (int i = 0; i < 4; i++) begin
         hm_u.wr(A_PW, 8'(8'ha0 | (8'h01 << i)), 1'b1, r);
         settle();
         `CHECK("path_ctl field", 4'(4'h1 << i), path_ctl)
         hm_u.rd(A_PR, d, r);
         `CHECK("path read", 8'(8'h10 | (8'h01 << i)), d)
      end
      hm_u.wr(A_PR, 8'h00, 1'b1, r);
      `CHECK("write to read index", RESP_SLVERR, r)
      hm_u.rd(A_PW, d, r);
      `CHECK("read of write index", RESP_SLVERR, r)
      $display("test path done");
      // Each analog power-down bit and the groups it turns off
      for (int i = 0; i < 4; i++) begin
         hm_u.wr(A_DW, 8'(8'ha0 | (8'h01 << i)), 1'b1, r);
         `CHECK("pd write resp", RESP_OKAY, r)
         settle();
         `CHECK("pd_state group", pd_map[i], pd_state)
         hm_u.rd(A_DR, d, r);
         `CHECK("pd read", 8'(8'h01 << i), d)
      end
      hm_u.wr(A_DW, 8'h00, 1'b0, r);
      hm_u.rd(A_DR, d, r);
      `CHECK("pd masked write", 8'h08, d)
      hm_u.rd(12'h000, d, r);
      `CHECK("unmapped resp", RESP_SLVERR, r)
      `CHECK("unmapped data", 8'h00, d)
      $display("test power done");
      // Warm reset register: the command triggers only with byte lane 0 strobed
      // Strobe off: the command byte is not written, so no pulse
      hm_u.wr(A_WM, WARM_CMD, 1'b0, r);
      settle();
      `CHECK("warm strobe off", 0, pulses)
      hm_u.wr(A_WM, WARM_CMD, 1'b1, r);
      settle();
      `CHECK("warm command", 1, pulses)
      $display("test warm register done");
      // Digital core down halts access until a warm reset
      hm_u.wr(A_DW, 8'h10, 1'b1, r);
      settle();
      `CHECK("pd_state digital", 7'b1100011, pd_state)
      hm_u.rd(A_DR, d, r);
      `CHECK("halted read", RESP_SLVERR, r)
      warm_reset_pin <= 1'b1;
      repeat (8) @(posedge aclk);
      warm_reset_pin <= 1'b0;
      `CHECK("pin pulse", 2, pulses)
      hm_u.rd(A_DR, d, r);
      `CHECK("access after warm", RESP_OKAY, r)
      `CHECK("digital bit kept", 8'h10, d)
      // Serial clocks are outside this block; aclk runs long before this
      hm_u.wr(A_DW, 8'h00, 1'b1, r);
      settle();
      `CHECK("pd_state resumed", 7'b0000000, pd_state)
      $display("test warm reset done");
      // Cold reset clears the digital core bit
      hm_u.wr(A_DW, 8'h10, 1'b1, r);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      hm_u.rd(A_DR, d, r);
      `CHECK("cold reset pd", 8'h43, d)
      $display("test cold reset done");
      close_out();
   end
endmodule
`default_nettype wire
